// File: src/sbr_base_regs.sv
`timescale 1ns/1ps
module sbr_base_regs (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // Register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Pins
   input  wire logic       cable_power_pin,
   input  wire logic       dual_port_strap,
   input  wire logic       contender_strap_pin,
   input  wire logic       link_power_status_input,
   // Events from the arbitration core
   input  wire logic       self_id_done,
   input  wire logic [5:0] self_id_node_addr,
   input  wire logic       tree_id_root,
   input  wire logic       bus_reset_event,
   input  wire logic       config_gap_load,
   input  wire logic [5:0] config_gap_value,
   input  wire logic       packet_busy,
   input  wire logic       config_timeout_event,
   input  wire logic       state_timeout_event,
   input  wire logic       port_event,
   input  wire logic       resume_event,
   // Controls to the arbitration core
   output logic            long_reset_start,
   output logic            short_reset_start,
   output logic            root_holdoff,
   output logic [5:0]      gap_count,
   output logic            link_activity,
   output logic            contender,
   output logic            accel_enable,
   output logic            node_address_valid,
   output logic            status_reg0_push
);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] cps_sync_r;
   logic [1:0] dual_sync_r;
   logic [1:0] cont_sync_r;
   logic [1:0] lps_sync_r;

   always_ff @(posedge clk_sys) begin
      cps_sync_r  <= {cps_sync_r[0], cable_power_pin};
      dual_sync_r <= {dual_sync_r[0], dual_port_strap};
      cont_sync_r <= {cont_sync_r[0], contender_strap_pin};
      lps_sync_r  <= {lps_sync_r[0], link_power_status_input};
   end

   wire cps_s  = cps_sync_r[1];
   wire dual_s = dual_sync_r[1];
   wire cont_s = cont_sync_r[1];
   wire lps_s  = lps_sync_r[1];

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic [5:0] node_addr_r;
   logic       node_valid_r;
   logic       root_r;
   logic       cps_prev_r;
   logic       rhb_r;
   logic       ibr_r;
   logic [5:0] gap_r;
   logic       gap_touched_r;
   logic       link_active_control_r;
   logic       cont_r;
   logic       cont_loaded_r;
   logic [2:0] pwr_class_r;
   logic       resume_interrupt_enable_r;
   logic       short_bus_reset_request_r;
   logic       configuration_timeout_flag_r;
   logic       cable_power_flag_r;
   logic       state_timeout_flag_r;
   logic       pei_r;
   logic       eaa_r;
   logic       emc_r;
   logic [2:0] page_r;
   logic [3:0] port_sel_r;
   logic [7:0] base_rdata_r;
   logic       rd_paged_r;
   logic       rd_paged_rsvd_r;
   sbr_pkg::sbr_state_t state_r;
   sbr_pkg::sbr_state_t state_nxt;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   wire       is_paged  = reg_addr[3];
   wire       wr_base   = reg_wr && !is_paged;
   wire       wr_r1     = wr_base && reg_addr == sbr_pkg::ADDR_GAP_RESET_CTRL;
   wire       wr_r4     = wr_base && reg_addr == sbr_pkg::ADDR_LINK_POWER_CTRL;
   wire       wr_r5     = wr_base && reg_addr == sbr_pkg::ADDR_INT_FEATURE_CTRL;
   wire       wr_r7     = wr_base && reg_addr == sbr_pkg::ADDR_PAGE_PORT_SEL;
   wire       page_rsvd = page_r >= sbr_pkg::PAGE_RSVD_LO &&
                          page_r <= sbr_pkg::PAGE_RSVD_HI;
   wire       wr_paged  = reg_wr && is_paged && !page_rsvd;
   wire [5:0] page_addr = {page_r, reg_addr[2:0]};

   // Bit 0 in the register map numbering is the MSB, so it sits at [7].
   wire w_rhb  = reg_wdata[7];
   wire w_ibr  = reg_wdata[6];
   wire w_lctl = reg_wdata[7];
   wire w_cont = reg_wdata[6];
   wire w_resume_interrupt_enable = reg_wdata[7];
   wire w_short_bus_reset_request = reg_wdata[6];
   wire w_configuration_timeout_flag = reg_wdata[5];
   wire w_cable_power_flag = reg_wdata[4];
   wire w_state_timeout_flag = reg_wdata[3];
   wire w_pei  = reg_wdata[2];
   wire w_eaa  = reg_wdata[1];
   wire w_emc  = reg_wdata[0];

   // ---------------------------------------------------------------
   // Read mux; base fields never look at the page.
   // ---------------------------------------------------------------
   wire [3:0] ports_val = dual_s ? sbr_pkg::PORTS_DUAL_VAL
                                 : sbr_pkg::PORTS_SINGLE_VAL;
   wire [7:0] rd_r0 = {node_addr_r, root_r, cps_s};
   wire [7:0] rd_r1 = {rhb_r, ibr_r, gap_r};
   wire [7:0] rd_r2 = {sbr_pkg::EXTENDED_SET_VAL, 1'b0,
                       ports_val};
   wire [7:0] rd_r3 = {sbr_pkg::SPEED_CAP_VAL, 1'b0,
                       sbr_pkg::REPEAT_DELAY_VAL};
   wire [7:0] rd_r4 = {link_active_control_r, cont_r, sbr_pkg::REPEAT_JITTER_VAL,
                       pwr_class_r};
   wire [7:0] rd_r5 = {resume_interrupt_enable_r, short_bus_reset_request_r, configuration_timeout_flag_r, cable_power_flag_r,
                       state_timeout_flag_r, pei_r, eaa_r, emc_r};
   wire [7:0] rd_r7 = {page_r, 1'b0, port_sel_r};
   logic [7:0] base_mux;

   always_comb begin
      unique case (reg_addr[2:0])
         3'h0:    base_mux = rd_r0;
         3'h1:    base_mux = rd_r1;
         3'h2:    base_mux = rd_r2;
         3'h3:    base_mux = rd_r3;
         3'h4:    base_mux = rd_r4;
         3'h5:    base_mux = rd_r5;
         3'h6:    base_mux = 8'h00;
         3'h7:    base_mux = rd_r7;
      endcase
   end

   // ---------------------------------------------------------------
   // Paged storage
   // ---------------------------------------------------------------
   logic [7:0] paged_rdata;

   sbr_page_mem u_page_mem (
      .clk_sys (clk_sys),
      .reset   (reset),
      .wr_en   (wr_paged),
      .wr_addr (page_addr),
      .wr_data (reg_wdata),
      .rd_addr (page_addr),
      .rd_data (paged_rdata)
   );

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         base_rdata_r    <= 8'h00;
         rd_paged_r      <= 1'b0;
         rd_paged_rsvd_r <= 1'b0;
      end else begin
         base_rdata_r    <= reg_rd ? base_mux : 8'h00;
         rd_paged_r      <= reg_rd && is_paged;
         rd_paged_rsvd_r <= page_rsvd;
      end
   end

   // The paged memory output is already a register; the final select
   // is a flop-fed mux so read data stand only in the following cycle.
   assign reg_rdata = !rd_paged_r      ? base_rdata_r :
                      rd_paged_rsvd_r  ? 8'h00 : paged_rdata;

   // ---------------------------------------------------------------
   // Node identity and root
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         node_addr_r  <= 6'h00;
         node_valid_r <= 1'b0;
         root_r       <= 1'b0;
         status_reg0_push <= 1'b0;
      end else begin
         status_reg0_push <= self_id_done;
         if (bus_reset_event) begin
            node_valid_r <= 1'b0;
            root_r       <= 1'b0;
         end else begin
            if (self_id_done) begin
               node_addr_r  <= self_id_node_addr;
               node_valid_r <= 1'b1;
            end
            if (tree_id_root) begin
               root_r <= 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Gap count and root holdoff
   // ---------------------------------------------------------------
   wire gap_load = wr_r1 || config_gap_load;
   wire [5:0] gap_val = wr_r1 ? reg_wdata[5:0] : config_gap_value;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rhb_r            <= 1'b0;
         gap_r            <= sbr_pkg::GAP_COUNT_RST;
         gap_touched_r    <= 1'b0;
      end else begin
         if (wr_r1) begin
            rhb_r <= w_rhb;
         end
         if (gap_load) begin
            gap_r         <= gap_val;
            gap_touched_r <= 1'b1;
         end else if (bus_reset_event) begin
            // A load survives exactly one bus reset; the next one with
            // no load in between restores the default.
            gap_touched_r <= 1'b0;
            if (!gap_touched_r) begin
               gap_r <= sbr_pkg::GAP_COUNT_RST;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Link control, contender, power class
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         link_active_control_r       <= 1'b1;
         cont_r        <= 1'b0;
         cont_loaded_r <= 1'b0;
         pwr_class_r   <= 3'h0;
      end else begin
         cont_loaded_r <= 1'b1;
         if (wr_r4) begin
            link_active_control_r     <= w_lctl;
            cont_r      <= w_cont;
            pwr_class_r <= reg_wdata[2:0];
         end else if (!cont_loaded_r) begin
            cont_r <= cont_s;
         end
      end
   end

   // ---------------------------------------------------------------
   // Register 5: enables and write-one-to-clear flags
   // ---------------------------------------------------------------
   wire cps_fall  = cps_prev_r && !cps_s;
   wire pei_set   = port_event || (resume_interrupt_enable_r && resume_event);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         resume_interrupt_enable_r     <= 1'b0;
         configuration_timeout_flag_r     <= 1'b0;
         cable_power_flag_r     <= 1'b1;
         state_timeout_flag_r     <= 1'b0;
         pei_r      <= 1'b0;
         eaa_r      <= 1'b0;
         emc_r      <= 1'b0;
         cps_prev_r <= 1'b0;
      end else begin
         cps_prev_r <= cps_s;
         if (wr_r5) begin
            resume_interrupt_enable_r <= w_resume_interrupt_enable;
            eaa_r  <= w_eaa;
            emc_r  <= w_emc;
         end
         // Set wins over a same-cycle write of one.
         configuration_timeout_flag_r <= config_timeout_event || (configuration_timeout_flag_r && !(wr_r5 && w_configuration_timeout_flag));
         cable_power_flag_r <= cps_fall || (cable_power_flag_r && !(wr_r5 && w_cable_power_flag));
         state_timeout_flag_r <= state_timeout_event || (state_timeout_flag_r && !(wr_r5 && w_state_timeout_flag));
         pei_r  <= pei_set || (pei_r && !(wr_r5 && w_pei));
      end
   end

   // ---------------------------------------------------------------
   // Page and port selection
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         page_r     <= sbr_pkg::PAGE_SEL_RST;
         port_sel_r <= sbr_pkg::PORT_SEL_RST;
      end else if (wr_r7) begin
         page_r     <= reg_wdata[7:5];
         port_sel_r <= reg_wdata[3:0];
      end
   end

   // ---------------------------------------------------------------
   // Bus reset requests
   // ---------------------------------------------------------------
   wire ibr_set  = wr_r1 && w_ibr;
   wire short_bus_reset_request_set = wr_r5 && w_short_bus_reset_request;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         sbr_pkg::SBR_IDLE: begin
            if (ibr_r || short_bus_reset_request_r) begin
               state_nxt = sbr_pkg::SBR_WAIT_IDLE;
            end
         end
         sbr_pkg::SBR_WAIT_IDLE: begin
            if (bus_reset_event) begin
               state_nxt = sbr_pkg::SBR_IDLE;
            end else if (!packet_busy) begin
               state_nxt = sbr_pkg::SBR_RESETTING;
            end
         end
         sbr_pkg::SBR_RESETTING: begin
            if (bus_reset_event) begin
               state_nxt = sbr_pkg::SBR_IDLE;
            end
         end
         default: state_nxt = sbr_pkg::SBR_IDLE;
      endcase
   end

   wire go_reset = state_r == sbr_pkg::SBR_WAIT_IDLE && !packet_busy &&
                   !bus_reset_event;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_r           <= sbr_pkg::SBR_IDLE;
         ibr_r             <= 1'b0;
         short_bus_reset_request_r            <= 1'b0;
         long_reset_start  <= 1'b0;
         short_reset_start <= 1'b0;
      end else begin
         state_r           <= state_nxt;
         long_reset_start  <= go_reset && ibr_r;
         short_reset_start <= go_reset && !ibr_r && short_bus_reset_request_r;
         if (bus_reset_event) begin
            ibr_r  <= 1'b0;
            short_bus_reset_request_r <= 1'b0;
         end else begin
            if (ibr_set) begin
               ibr_r <= 1'b1;
            end
            if (short_bus_reset_request_set) begin
               short_bus_reset_request_r <= 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Status outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         root_holdoff       <= 1'b0;
         gap_count          <= sbr_pkg::GAP_COUNT_RST;
         link_activity      <= 1'b0;
         contender          <= 1'b0;
         accel_enable       <= 1'b0;
         node_address_valid <= 1'b0;
      end else begin
         root_holdoff       <= rhb_r;
         gap_count          <= gap_r;
         link_activity      <= link_active_control_r && lps_s;
         contender          <= cont_r;
         accel_enable       <= eaa_r;
         node_address_valid <= node_valid_r;
      end
   end

endmodule

// File: src/sbr_page_mem.sv
`timescale 1ns/1ps
// Storage for the paged registers: 8 pages of 8 bytes each, with a
// registered read port.
module sbr_page_mem (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // Write port
   input  wire logic       wr_en,
   input  wire logic [5:0] wr_addr,
   input  wire logic [7:0] wr_data,
   // Read port
   input  wire logic [5:0] rd_addr,
   output logic      [7:0] rd_data
);

   logic [7:0] mem_r [64];

   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem_r[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rd_data <= sbr_pkg::PAGED_DATA_RST;
      end else begin
         rd_data <= mem_r[rd_addr];
      end
   end

endmodule

// File: src/sbr_pkg.sv
package sbr_pkg;

   // ---------------------------------------------------------------
   // Register addresses
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_NODE_ID_STATUS   = 4'h0;
   localparam logic [3:0] ADDR_GAP_RESET_CTRL   = 4'h1;
   localparam logic [3:0] ADDR_PORT_COUNT_INFO  = 4'h2;
   localparam logic [3:0] ADDR_SPEED_DELAY_INFO = 4'h3;
   localparam logic [3:0] ADDR_LINK_POWER_CTRL  = 4'h4;
   localparam logic [3:0] ADDR_INT_FEATURE_CTRL = 4'h5;
   localparam logic [3:0] ADDR_RESERVED_SIX     = 4'h6;
   localparam logic [3:0] ADDR_PAGE_PORT_SEL    = 4'h7;
   localparam logic [3:0] ADDR_PAGED_BASE       = 4'h8;

   // ---------------------------------------------------------------
   // Constant fields and reset values
   // ---------------------------------------------------------------
   localparam logic [2:0] EXTENDED_SET_VAL  = 3'h7;
   localparam logic [3:0] PORTS_DUAL_VAL    = 4'h2;
   localparam logic [3:0] PORTS_SINGLE_VAL  = 4'h1;
   localparam logic [2:0] SPEED_CAP_VAL     = 3'h2;
   localparam logic [3:0] REPEAT_DELAY_VAL  = 4'h1;
   localparam logic [2:0] REPEAT_JITTER_VAL = 3'h0;
   localparam logic [5:0] GAP_COUNT_RST     = 6'h3F;
   localparam logic [2:0] PAGE_SEL_RST      = 3'h0;
   localparam logic [3:0] PORT_SEL_RST      = 4'h0;
   localparam logic [7:0] PAGED_DATA_RST    = 8'h00;

   // ---------------------------------------------------------------
   // Pages that carry paged content; 2 to 6 are reserved
   // ---------------------------------------------------------------
   localparam logic [2:0] PAGE_RSVD_LO = 3'h2;
   localparam logic [2:0] PAGE_RSVD_HI = 3'h6;

   // ---------------------------------------------------------------
   // Bus reset control states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SBR_IDLE      = 2'b00,
      SBR_WAIT_IDLE = 2'b01,
      SBR_RESETTING = 2'b10
   } sbr_state_t;

endpackage

// File: test/sbr_core_model.sv
`timescale 1ns/1ps
module sbr_core_model (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // Reset requests
   input  wire logic       long_reset_start,
   input  wire logic       short_reset_start,
   input  wire logic       ext_reset,
   // Node behaviour
   input  wire logic       slow,
   input  wire logic       make_root,
   input  wire logic [5:0] node_addr,
   // Events
   output logic            bus_reset_event,
   output logic            tree_id_root,
   output logic            self_id_done,
   output logic [5:0]      self_id_node_addr
);
   // ---------------------------------------------------------------
   // Bus reset, tree and self identification sequence
   // ---------------------------------------------------------------
   logic       run_r;
   logic [4:0] cnt_r;
   wire  [4:0] rst_at = slow ? 5'h0C : 5'h01;
   wire        go = long_reset_start | short_reset_start | ext_reset;
   wire        sid = run_r && cnt_r == rst_at + 5'h05;

   // The address lines toggle outside self-ID so a stale value never
   // looks valid.
   always_ff @(posedge clk_sys) begin
      bus_reset_event <= run_r && cnt_r == rst_at;
      tree_id_root <= run_r && make_root && cnt_r == rst_at + 5'h03;
      self_id_done <= sid;
      self_id_node_addr <= sid ? node_addr : ~self_id_node_addr;
      if (reset) begin
         run_r <= 1'b0;
         cnt_r <= 5'h00;
         self_id_node_addr <= 6'h00;
      end else if (go && !run_r) begin
         run_r <= 1'b1;
         cnt_r <= 5'h00;
      end else if (run_r) begin
         cnt_r <= cnt_r + 5'h01;
         run_r <= !sid;
      end
   end
endmodule

// File: test/sbr_properties.sv
`timescale 1ns/1ps
module sbr_properties (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       reset,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // Core side
   input wire logic       packet_busy,
   input wire logic       bus_reset_event,
   input wire logic       config_gap_load,
   input wire logic [5:0] config_gap_value,
   input wire logic       self_id_done,
   input wire logic       long_reset_start,
   input wire logic [5:0] gap_count,
   input wire logic       node_address_valid,
   input wire logic       status_reg0_push
);
   // ---------------------------------------------------------------
   // Port properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   property p_rsvd_zero;
      reg_rd && reg_addr == 4'h6 |=> reg_rdata == 8'h00;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero)
      else $error("reserved register read not zero");

   property p_ext_set;
      reg_rd && reg_addr == 4'h2 |=> reg_rdata[7:4] == 4'hE;
   endproperty
   a_ext_set: assert property (p_ext_set)
      else $error("extended set field wrong");

   property p_speed_delay;
      reg_rd && reg_addr == 4'h3 |=> reg_rdata == 8'h41;
   endproperty
   a_speed_delay: assert property (p_speed_delay)
      else $error("speed or delay field wrong");

   // The write is excluded because it may load the same register.
   property p_gap_load;
      config_gap_load && !reg_wr && !bus_reset_event
         |-> ##2 gap_count == $past(config_gap_value, 2);
   endproperty
   a_gap_load: assert property (p_gap_load)
      else $error("gap count not loaded from packet");

   property p_gap_hw;
      $fell(reset) |-> gap_count == 6'h3F;
   endproperty
   a_gap_hw: assert property (p_gap_hw)
      else $error("gap count not all ones after reset");

   property p_sid_push;
      self_id_done && !bus_reset_event
         |=> status_reg0_push ##1 node_address_valid;
   endproperty
   a_sid_push: assert property (p_sid_push)
      else $error("no status push or valid address");

   property p_long_wait;
      long_reset_start |-> !$past(packet_busy);
   endproperty
   a_long_wait: assert property (p_long_wait)
      else $error("long reset started during packet");

   property p_req_clear;
      bus_reset_event && !reg_wr ##1
         reg_rd && (reg_addr == 4'h1 || reg_addr == 4'h5)
         |=> !reg_rdata[6];
   endproperty
   a_req_clear: assert property (p_req_clear)
      else $error("reset request survived bus reset");
endmodule

// File: test/test_sbr_base_regs.sv
`timescale 1ns/1ps
module test_sbr_base_regs;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic       clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, d0, d1;
   logic       cable_power_pin = 1'b1, dual_port_strap = 1'b1;
   logic       contender_strap_pin = 1'b1, link_power_status_input = 1'b0;
   logic       packet_busy = 1'b0, config_gap_load = 1'b0;
   logic [5:0] config_gap_value = 6'h00, node_addr = 6'h00, g, g2;
   logic       config_timeout_event = 1'b0, state_timeout_event = 1'b0;
   logic       port_event = 1'b0, resume_event = 1'b0, ext_reset = 1'b0;
   logic       slow = 1'b0, make_root = 1'b0, rd_d = 1'b0;
   logic       bus_reset_event, tree_id_root, self_id_done;
   logic [5:0] self_id_node_addr, gap_count;
   logic       long_reset_start, short_reset_start, root_holdoff;
   logic       link_activity, contender, accel_enable;
   logic       node_address_valid, status_reg0_push;
   logic [7:0] long_n = 8'h00, short_n = 8'h00, exp_q[$];
   logic [31:0] r;
   int         bad_count = 0, checked = 0, cyc_n = 0, seed = 85, i;
   logic [7:0] rst_v [16] = '{0: 8'h01, 1: 8'h3F, 2: 8'hE2, 3: 8'h41,
                              4: 8'hC0, 5: 8'h10, default: 8'h00};
   logic [3:0] ro_a [4] = '{4'h0, 4'h2, 4'h3, 4'h6};

   sbr_base_regs sbr_base_regs_i (.*);
   sbr_core_model sbr_core_model_i (.*);

   initial begin
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      cyc(1);
      reg_wr <= 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      cyc(1);
      reg_rd <= 1'b0;
      cyc(1);
   endtask
   // Returns just after the edge that saw the event, so a read can
   // start in the very next cycle.
   task automatic wait_ev(input bit sid);
      for (int k = 0; k < 60 && (sid ? self_id_done : bus_reset_event)
           !== 1'b1; k++) cyc(1);
   endtask

   // Read data is compared one cycle after each read strobe.
   always @(posedge clk_sys) begin
      rd_d <= reg_rd;
      cyc_n++;
      if (long_reset_start === 1'b1) long_n++;
      if (short_reset_start === 1'b1) short_n++;
      if (rd_d) chk(reg_rdata, exp_q.pop_front());
      if (cyc_n == 3000) begin
         bad_count++;
         print_verdict();
      end
   end

   initial begin
      r = $random(seed);
      {d0, d1, g, g2} = r[27:0];
      cyc(20);
      reset <= 1'b0;
      cyc(1);
      // The paged storage has no reset, so page 0 is cleared first.
      for (i = 8; i < 16; i++) wr(i[3:0], 8'h00);
      for (i = 0; i < 16; i++) rd(i[3:0], rst_v[i]);
      wr(4'h1, {2'b10, g});
      rd(4'h1, {2'b10, g});
      wr(4'h7, 8'h33);
      rd(4'h7, 8'h23);
      wr(4'hB, d1);
      wr(4'h7, 8'h00);
      wr(4'hB, d0);
      rd(4'hB, d0);
      wr(4'h7, 8'h20);
      rd(4'hB, d1);
      wr(4'h7, 8'h60);
      wr(4'h9, d0);
      rd(4'h9, 8'h00);
      rd(4'h2, 8'hE2);
      wr(4'h7, 8'h00);
      for (i = 0; i < 4; i++) wr(ro_a[i], 8'hFF);
      for (i = 0; i < 4; i++) rd(ro_a[i], rst_v[ro_a[i]]);
      packet_busy <= 1'b1;
      wr(4'h1, {2'b11, g});
      rd(4'h1, {2'b11, g});
      chk(long_n, 8'h00);
      packet_busy <= 1'b0;
      make_root <= 1'b1;
      node_addr <= r[31:26];
      wait_ev(0);
      rd(4'h1, {2'b10, g});
      chk(long_n, 8'h01);
      chk({7'h00, root_holdoff}, 8'h01);
      wait_ev(1);
      cyc(1);
      rd(4'h0, {node_addr, 2'b11});
      make_root <= 1'b0;
      ext_reset <= 1'b1;
      cyc(1);
      ext_reset <= 1'b0;
      wait_ev(0);
      rd(4'h1, 8'hBF);
      wait_ev(1);
      cyc(1);
      rd(4'h0, {node_addr, 2'b01});
      config_gap_value <= g2;
      config_gap_load <= 1'b1;
      cyc(1);
      config_gap_load <= 1'b0;
      ext_reset <= 1'b1;
      cyc(1);
      ext_reset <= 1'b0;
      wait_ev(0);
      rd(4'h1, {2'b10, g2});
      wait_ev(1);
      slow <= 1'b1;
      wr(4'h5, 8'h40);
      wait_ev(0);
      rd(4'h5, 8'h10);
      chk(short_n, 8'h01);
      wait_ev(1);
      config_timeout_event <= 1'b1;
      state_timeout_event <= 1'b1;
      port_event <= 1'b1;
      cyc(1);
      config_timeout_event <= 1'b0;
      state_timeout_event <= 1'b0;
      port_event <= 1'b0;
      rd(4'h5, 8'h3C);
      wr(4'h5, 8'h3C);
      rd(4'h5, 8'h00);
      for (i = 0; i < 2; i++) begin
         resume_event <= 1'b1;
         cyc(1);
         resume_event <= 1'b0;
         rd(4'h5, i == 0 ? 8'h00 : 8'h87);
         wr(4'h5, 8'h83);
      end
      chk({7'h00, accel_enable}, 8'h01);
      cable_power_pin <= 1'b0;
      cyc(4);
      rd(4'h0, {node_addr, 2'b00});
      rd(4'h5, 8'h97);
      link_power_status_input <= 1'b1;
      cyc(4);
      chk({7'h00, link_activity}, 8'h01);
      wr(4'h4, 8'h40);
      cyc(2);
      chk({7'h00, link_activity}, 8'h00);
      chk({7'h00, contender}, 8'h01);
      rd(4'h4, 8'h40);
      dual_port_strap <= 1'b0;
      cyc(3);
      rd(4'h2, 8'hE1);
      cyc(2);
      chk(8'(exp_q.size()), 8'h00);
      print_verdict();
   end
endmodule

bind sbr_base_regs sbr_properties sbr_properties_i (
   .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .packet_busy(packet_busy), .bus_reset_event(bus_reset_event),
   .config_gap_load(config_gap_load),
   .config_gap_value(config_gap_value), .self_id_done(self_id_done),
   .long_reset_start(long_reset_start), .gap_count(gap_count),
   .node_address_valid(node_address_valid),
   .status_reg0_push(status_reg0_push));
